// ===== core/ssp_top.sv
// ssp_top: serial shift port with registers, master/slave shifting and filters
// assumes pins are synchronous to mclk_in; register port answers reads a cycle later
`timescale 1ns/1ps
module ssp_top (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// serial pins
	input wire logic sin_in,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oen_out,
	output logic sout_out,
	output logic sout_route_out,
	// interrupt sharing
	input wire logic port_irq_in,
	output logic irq_out
);
	logic [7:0] mode_reg; // transfer_mode_control
	logic [7:0] rate_reg; // rate_frame_flag
	logic route_reg; // output_route_control bit 0
	logic [7:0] data_reg; // serial_shift_data
	logic [7:0] rdata_reg;
	logic [3:0] cnt_reg; // bits shifted
	logic sck_reg; // master shift clock level
	logic sck_prev_reg; // previous effective clock level
	logic sin_prev_reg; // previous filtered input
	logic sout_reg;
	logic irq_pend_reg; // raw request pulse memory
	ssp_pkg::ssp_state_e state_reg;
	logic sin_f, sck_f, tick, eff_clk, lead, trail, cap, chg;
	logic master, in_bit, done, abort, start_ok, wr_mode, wr_rate;

	assign master = mode_reg[ssp_pkg::MODE_CLKSRC];
	assign wr_mode = wr_in && (addr_in == ssp_pkg::ADDR_MODE);
	assign wr_rate = wr_in && (addr_in == ssp_pkg::ADDR_RATE);

	// input noise filters
	ssp_filter u_fsin (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.bypass_in(mode_reg[ssp_pkg::MODE_FILT_DIS]),
		.raw_in(sin_in),
		.clean_out(sin_f)
	);
	ssp_filter u_fsck (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.bypass_in(mode_reg[ssp_pkg::MODE_FILT_DIS]),
		.raw_in(sck_in),
		.clean_out(sck_f)
	);

	// master clock generator; rate only used in master mode
	ssp_rate u_rate (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.run_in((state_reg == ssp_pkg::SSP_SHIFT) && master),
		.code_in(rate_reg[ssp_pkg::CD_W-1:0]),
		.tick_out(tick)
	);

	// master toggles its clock each tick, idle at polarity level
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sck_reg <= 1'b0;
		end else if (state_reg != ssp_pkg::SSP_SHIFT) begin
			// follow a polarity written with run so no false edge opens the frame
			sck_reg <= wr_mode ? wdata_in[ssp_pkg::MODE_POL] : mode_reg[ssp_pkg::MODE_POL];
		end else if (tick) begin
			sck_reg <= ~sck_reg;
		end
	end

	// effective clock normalised so idle level reads low
	assign eff_clk = (master ? sck_reg : sck_f) ^ mode_reg[ssp_pkg::MODE_POL];
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sck_prev_reg <= 1'b0;
		end else begin
			sck_prev_reg <= eff_clk;
		end
	end
	assign lead = eff_clk && !sck_prev_reg && (state_reg == ssp_pkg::SSP_SHIFT);
	assign trail = !eff_clk && sck_prev_reg && (state_reg == ssp_pkg::SSP_SHIFT);
	// phase zero captures on leading, phase one on trailing edge
	assign cap = mode_reg[ssp_pkg::MODE_PHASE] ? trail : lead;
	assign chg = mode_reg[ssp_pkg::MODE_PHASE] ? lead : trail;
	assign in_bit = mode_reg[ssp_pkg::MODE_IN_EN] ? sin_f : 1'b0;
	assign done = cap && (cnt_reg + 4'h1 == rate_reg[ssp_pkg::LEN_LSB +: ssp_pkg::LEN_W]);
	assign abort = wr_mode && !wdata_in[ssp_pkg::MODE_RUN] && (state_reg != ssp_pkg::SSP_IDLE);

	// edge tracker for start-on-input
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sin_prev_reg <= 1'b0;
		end else begin
			sin_prev_reg <= sin_f;
		end
	end
	// start when input rises, or already high when run arrives
	assign start_ok = !mode_reg[ssp_pkg::MODE_START] || (sin_f && !sin_prev_reg) || sin_f;

	// transfer sequencer
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= ssp_pkg::SSP_IDLE;
		end else begin
			unique case (state_reg)
				ssp_pkg::SSP_IDLE: begin
					if (wr_mode && wdata_in[ssp_pkg::MODE_RUN]) begin
						state_reg <= ssp_pkg::SSP_WAIT;
					end
				end
				ssp_pkg::SSP_WAIT: begin
					if (abort) begin
						state_reg <= ssp_pkg::SSP_IDLE;
					end else if (start_ok) begin
						state_reg <= ssp_pkg::SSP_SHIFT;
					end
				end
				ssp_pkg::SSP_SHIFT: begin
					// continues even if input falls
					if (abort || done) begin
						state_reg <= ssp_pkg::SSP_IDLE;
					end
				end
				default: state_reg <= ssp_pkg::SSP_IDLE;
			endcase
		end
	end

	// bit counter
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_reg <= 4'h0;
		end else if (state_reg != ssp_pkg::SSP_SHIFT) begin
			cnt_reg <= 4'h0;
		end else if (cap) begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end

	// mode register; hardware clears run at end of frame
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode_reg <= ssp_pkg::MODE_RESET;
		end else if (wr_mode) begin
			mode_reg <= wdata_in;
		end else if (done) begin
			mode_reg[ssp_pkg::MODE_RUN] <= 1'b0;
		end
	end

	// rate/frame register; flag set by hardware wins over clear
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rate_reg <= ssp_pkg::RATE_RESET;
		end else begin
			if (wr_rate) begin
				rate_reg[6:0] <= wdata_in[6:0];
				if (!wdata_in[ssp_pkg::RATE_FLAG]) begin
					rate_reg[ssp_pkg::RATE_FLAG] <= 1'b0;
				end
			end
			if ((done || abort) && mode_reg[ssp_pkg::MODE_IRQ_EN]) begin
				rate_reg[ssp_pkg::RATE_FLAG] <= 1'b1;
			end
		end
	end

	// route register, write only
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			route_reg <= ssp_pkg::ROUTE_RESET[0];
		end else if (wr_in && addr_in == ssp_pkg::ADDR_ROUTE) begin
			route_reg <= wdata_in[0];
		end
	end

	// shift register: load by write, shift left on capture
	always_ff @(posedge mclk_in) begin
		if (wr_in && addr_in == ssp_pkg::ADDR_DATA) begin
			data_reg <= wdata_in;
		end else if (cap) begin
			data_reg <= {data_reg[6:0], in_bit};
		end
	end

	// serial output: phase zero shows top bit once loaded
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sout_reg <= 1'b0;
		end else if (!mode_reg[ssp_pkg::MODE_PHASE] && state_reg != ssp_pkg::SSP_SHIFT) begin
			sout_reg <= data_reg[7];
		end else if (chg) begin
			// top bit is always the next one out; phase zero has already shifted
			sout_reg <= data_reg[7];
		end
	end

	// interrupt memory of the last request
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_pend_reg <= 1'b0;
		end else begin
			irq_pend_reg <= rate_reg[ssp_pkg::RATE_FLAG];
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_reg <= 8'h00;
		end else if (rd_in) begin
			unique case (addr_in)
				ssp_pkg::ADDR_DATA: rdata_reg <= data_reg;
				ssp_pkg::ADDR_RATE: rdata_reg <= rate_reg;
				ssp_pkg::ADDR_MODE: rdata_reg <= mode_reg;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	assign rdata_out = rdata_reg;
	assign sck_out = sck_reg;
	assign sck_oen_out = !master;
	assign sout_out = sout_reg;
	assign sout_route_out = route_reg;
	// masked serial request shared with port request
	assign irq_out = (irq_pend_reg && mode_reg[ssp_pkg::MODE_IRQ_EN]) || port_irq_in;
endmodule

// ===== core/ssp_pkg.sv
// ssp_pkg: constants shared by the serial shift port design files
// assumes nothing beyond a SystemVerilog compiler
package ssp_pkg;
	// register offsets on the core data bus
	localparam logic [7:0] ADDR_ROUTE = 8'hDD;
	localparam logic [7:0] ADDR_DATA = 8'hE0;
	localparam logic [7:0] ADDR_RATE = 8'hE1;
	localparam logic [7:0] ADDR_MODE = 8'hE2;
	// reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h00;
	localparam logic [7:0] ROUTE_RESET = 8'h00;
	// mode control bit positions
	localparam int MODE_RUN = 7;
	localparam int MODE_IRQ_EN = 6;
	localparam int MODE_PHASE = 5;
	localparam int MODE_CLKSRC = 4;
	localparam int MODE_IN_EN = 3;
	localparam int MODE_START = 2;
	localparam int MODE_FILT_DIS = 1;
	localparam int MODE_POL = 0;
	// rate/frame register fields
	localparam int RATE_FLAG = 7;
	localparam int LEN_LSB = 3;
	localparam int LEN_W = 4;
	localparam int CD_W = 3;
	// base clock = core clock divided by 13
	localparam int BASE_DIV = 13;
	// shift state machine
	typedef enum logic [1:0] {
		SSP_IDLE = 2'b00,
		SSP_WAIT = 2'b01,
		SSP_SHIFT = 2'b10
	} ssp_state_e;
endpackage

// ===== core/ssp_filter.sv
// ssp_filter: two-sample glitch filter for one serial input
// assumes the input is already synchronous to mclk_in
`timescale 1ns/1ps
module ssp_filter (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// control and data
	input wire logic bypass_in,
	input wire logic raw_in,
	output logic clean_out
);
	logic s1_reg; // previous sample
	logic held_reg; // filtered level

	// sample the raw input
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_reg <= 1'b0;
		end else begin
			s1_reg <= raw_in;
		end
	end

	// accept a new level only after two agreeing samples
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			held_reg <= 1'b0;
		end else if (s1_reg == raw_in) begin
			held_reg <= raw_in;
		end
	end

	// bypass passes the raw level straight through
	assign clean_out = bypass_in ? raw_in : held_reg;
endmodule

// ===== core/ssp_rate.sv
// ssp_rate: base clock divider (by 13) and rate divider for master mode
// assumes one clock; emits one-cycle ticks of the bit clock half periods
`timescale 1ns/1ps
module ssp_rate #(
	parameter int BASE = ssp_pkg::BASE_DIV
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// control
	input wire logic run_in,
	input wire logic [2:0] code_in,
	// half-period tick of the shift clock
	output logic tick_out
);
	logic [3:0] base_reg; // divide-by-13 counter
	logic [7:0] rate_reg; // rate counter
	logic base_tick;
	logic [7:0] limit;

	// code to terminal count 0,1,3..63, 255: divide by 1,2,4..64, 256
	function automatic logic [7:0] rate_limit(input logic [2:0] c);
		if (c == 3'h7) begin
			rate_limit = 8'hFF;
		end else begin
			rate_limit = 8'((9'h001 << c) - 9'h001);
		end
	endfunction

	assign limit = rate_limit(code_in);
	assign base_tick = (base_reg == 4'(BASE - 1));

	// base divider, held cleared when idle
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			base_reg <= 4'h0;
		end else if (!run_in || base_tick) begin
			base_reg <= 4'h0;
		end else begin
			base_reg <= base_reg + 4'h1;
		end
	end

	// rate divider counts base ticks
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rate_reg <= 8'h00;
		end else if (!run_in) begin
			rate_reg <= 8'h00;
		end else if (base_tick) begin
			rate_reg <= (rate_reg >= limit) ? 8'h00 : rate_reg + 8'h01;
		end
	end

	assign tick_out = base_tick && (rate_reg >= limit);
endmodule

// ===== verif/ssp_props_properties.sv
// ssp_props: port-level assertions for the serial shift port
// assumes a single mclk_in domain and the asynchronous active-low rstn_in
`timescale 1ns/1ps
module ssp_props (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	// pins
	input wire logic sck_out,
	input wire logic sck_oen_out,
	input wire logic sout_route_out,
	input wire logic port_irq_in,
	input wire logic irq_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	// mode write followed by a mode read one idle cycle later
	sequence s_mode_wr;
		wr_in && addr_in == ssp_pkg::ADDR_MODE;
	endsequence
	sequence s_mode_rd;
		rd_in && addr_in == ssp_pkg::ADDR_MODE;
	endsequence
	property p_reset_idle;
		$rose(rstn_in) |-> sck_oen_out && !sout_route_out && !irq_out;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
	property p_port_or;
		port_irq_in |-> ##[0:1] irq_out;
	endproperty
	a_port_or: assert property (p_port_or) else $error("port request not passed on");
	property p_sck_hold;
		$fell(sck_out) |=> $stable(sck_out) [*8];
	endproperty
	a_sck_hold: assert property (p_sck_hold) else $error("shift clock half period too short");
	property p_route_rd;
		rd_in && addr_in == ssp_pkg::ADDR_ROUTE |=> rdata_out == 8'h00;
	endproperty
	a_route_rd: assert property (p_route_rd) else $error("route register readable");
	property p_unmapped_rd;
		rd_in && !(addr_in inside {8'hDD, 8'hE0, 8'hE1, 8'hE2}) |=> rdata_out == 8'h00;
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
	property p_mode_rw;
		s_mode_wr ##2 s_mode_rd |=> (rdata_out & 8'h7F) == ($past(wdata_in, 3) & 8'h7F);
	endproperty
	a_mode_rw: assert property (p_mode_rw) else $error("mode bits not kept");
	property p_master_on;
		wr_in && addr_in == ssp_pkg::ADDR_MODE && wdata_in[4] |=> ##[0:1] !sck_oen_out;
	endproperty
	a_master_on: assert property (p_master_on) else $error("master does not drive clock");
	property p_route_on;
		wr_in && addr_in == ssp_pkg::ADDR_ROUTE && wdata_in[0] |=> ##[0:1] sout_route_out;
	endproperty
	a_route_on: assert property (p_route_on) else $error("serial output not routed");
endmodule
bind ssp_top ssp_props ssp_chk_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sck_out(sck_out),
	.sck_oen_out(sck_oen_out), .sout_route_out(sout_route_out), .port_irq_in(port_irq_in), .irq_out(irq_out));

// ===== verif/ssp_far_model.sv
// ssp_far_model: external serial peripheral in slave role, mode with idle-low clock
// assumes the device is master; sends msb first, changes data on falling clock
`timescale 1ns/1ps
module ssp_far_model (
	// select and data to send
	input wire logic cs_in,
	input wire logic [7:0] tx_in,
	// serial lines
	input wire logic sck_in,
	input wire logic sdo_in,
	output logic sdi_out,
	output logic [7:0] rx_out
);
	logic [7:0] tx_reg; // outgoing bits
	// capture on the rising (leading) edge, msb first
	always @(posedge sck_in) rx_out <= {rx_out[6:0], sdo_in};
	// load while deselected, shift on falling edge
	always @(negedge sck_in or negedge cs_in) begin
		if (!cs_in) tx_reg <= tx_in;
		else tx_reg <= {tx_reg[6:0], ~tx_reg[0]};
	end
	// deselected line shows the inverse of the top bit to send
	assign sdi_out = cs_in ? tx_reg[7] : ~tx_reg[7];
endmodule

// ===== verif/tb.sv
// tb: self-checking bench for the serial shift port in master and slave mode
// assumes ssp_pkg, the design files and the partner model are compiled first
`timescale 1ns/1ps
module tb;
	logic mclk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, port_irq_in = 1'b0, cs = 1'b1;
	logic sck_x = 1'b0; // external master clock for slave runs
	logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, rx, v;
	logic sin_in, sck_out, sck_oen_out, sout_out, sout_route_out, irq_out;
	int mismatches = 0, n_checks = 0;
	always #4 mclk_in = ~mclk_in;
	ssp_top dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sin_in(sin_in), .sck_in(sck_x),
		.sck_out(sck_out), .sck_oen_out(sck_oen_out), .sout_out(sout_out),
		.sout_route_out(sout_route_out), .port_irq_in(port_irq_in), .irq_out(irq_out));
	// port line four is taken as a plain input here, the pin is modelled by the far side
	ssp_far_model far_u (.cs_in(cs), .tx_in(8'h3C), .sck_in(sck_out), .sdo_in(sout_out),
		.sdi_out(sin_in), .rx_out(rx));
	// compare and count
	task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask
	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
		#1;
	endtask
	// one-cycle read, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		addr_in <= a; rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask
	// poll the run flag under a bound
	task automatic wait_idle;
		int i;
		i = 0;
		v = 8'h80;
		while (v[7] && i < 400) begin
			rd(ssp_pkg::ADDR_MODE, v);
			i++;
		end
		chk("run flag", {7'h00, v[7]}, 8'h00);
	endtask
	// reset values and unmapped places
	task automatic t_reset;
		rd(ssp_pkg::ADDR_MODE, v); chk("mode", v, 8'h00);
		rd(ssp_pkg::ADDR_RATE, v); chk("rate", v, 8'h00);
		rd(ssp_pkg::ADDR_ROUTE, v); chk("route", v, 8'h00);
		rd(8'h10, v); chk("unmapped", v, 8'h00);
		chk("clock enable", {7'h00, sck_oen_out}, 8'h01);
	endtask
	// full byte exchange with interrupt, then flag clear
	task automatic t_master;
		cs <= 1'b0;
		@(posedge mclk_in);
		cs <= 1'b1;
		wr(ssp_pkg::ADDR_RATE, 8'h40);
		wr(ssp_pkg::ADDR_DATA, 8'hA5);
		wr(ssp_pkg::ADDR_ROUTE, 8'h01);
		wr(ssp_pkg::ADDR_MODE, 8'hDA);
		chk("route pin", {7'h00, sout_route_out}, 8'h01);
		chk("clock enable", {7'h00, sck_oen_out}, 8'h00);
		wait_idle();
		rd(ssp_pkg::ADDR_DATA, v); chk("received", v, 8'h3C);
		chk("far received", rx, 8'hA5);
		rd(ssp_pkg::ADDR_RATE, v); chk("flag set", v, 8'hC0);
		chk("irq", {7'h00, irq_out}, 8'h01);
		wr(ssp_pkg::ADDR_RATE, 8'h40);
		rd(ssp_pkg::ADDR_RATE, v); chk("flag clear", v, 8'h40);
		chk("irq off", {7'h00, irq_out}, 8'h00);
		cs <= 1'b0;
	endtask
	// four-bit frame with input disabled and no interrupt
	task automatic t_zero;
		wr(ssp_pkg::ADDR_RATE, 8'h20);
		wr(ssp_pkg::ADDR_DATA, 8'hFF);
		wr(ssp_pkg::ADDR_MODE, 8'h92);
		wait_idle();
		rd(ssp_pkg::ADDR_DATA, v); chk("zeros in", v, 8'hF0);
		rd(ssp_pkg::ADDR_RATE, v); chk("no flag", v, 8'h20);
		chk("irq masked", {7'h00, irq_out}, 8'h00);
	endtask
	// inverted polarity, shifted phase, input disabled
	task automatic t_pol;
		wr(ssp_pkg::ADDR_RATE, 8'h40);
		wr(ssp_pkg::ADDR_DATA, 8'h96);
		wr(ssp_pkg::ADDR_MODE, 8'hB3);
		wait_idle();
		chk("far received pol", rx, 8'h96);
		rd(ssp_pkg::ADDR_DATA, v); chk("zeros pol", v, 8'h00);
		chk("clock rests high", {7'h00, sck_out}, 8'h01);
	endtask
	// slave frame of three bits clocked from outside through the filters
	task automatic t_slave;
		wr(ssp_pkg::ADDR_RATE, 8'h18);
		wr(ssp_pkg::ADDR_DATA, 8'hE0);
		wr(ssp_pkg::ADDR_MODE, 8'h80);
		chk("slave clock enable", {7'h00, sck_oen_out}, 8'h01);
		repeat (3) begin
			repeat (4) @(posedge mclk_in);
			sck_x <= 1'b1;
			repeat (4) @(posedge mclk_in);
			sck_x <= 1'b0;
		end
		wait_idle();
		rd(ssp_pkg::ADDR_DATA, v); chk("slave shifted", v, 8'h00);
	endtask
	// abort in mid-frame at the slowest rate
	task automatic t_abort;
		wr(ssp_pkg::ADDR_RATE, 8'h47);
		wr(ssp_pkg::ADDR_MODE, 8'hDA);
		rd(ssp_pkg::ADDR_MODE, v); chk("running", v, 8'hDA);
		wr(ssp_pkg::ADDR_MODE, 8'h5A);
		rd(ssp_pkg::ADDR_MODE, v); chk("stopped", v, 8'h5A);
		rd(ssp_pkg::ADDR_RATE, v); chk("abort flag", v, 8'hC7);
		wr(ssp_pkg::ADDR_RATE, 8'h47);
	endtask
	// shared request line
	task automatic t_port;
		@(posedge mclk_in) port_irq_in <= 1'b1;
		@(posedge mclk_in) #1 chk("port irq", {7'h00, irq_out}, 8'h01);
		@(posedge mclk_in) port_irq_in <= 1'b0;
	endtask
	// verdict and end of run
	task automatic end_sim;
		if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog well above the longest expected run
	initial begin
		repeat (40000) @(posedge mclk_in);
		mismatches++;
		end_sim();
	end
	// main sequence
	initial begin
		repeat (20) @(posedge mclk_in);
		rstn_in <= 1'b1;
		t_reset();
		t_master();
		t_zero();
		t_pol();
		t_abort();
		t_slave();
		t_port();
		end_sim();
	end
endmodule
